// *** dv/spl_framer_model.sv ***
// Framer model on the transmit side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module spl_framer_model (
	input  wire logic                     clk_in,
	output logic                          tx_word_clk_out,
	output logic [spl_pkg::TX_W-1:0]      tx_word_out,
	output logic                          tx_parity_out
);
	import spl_pkg::*;
	// Idle levels at time zero
	initial begin
		tx_word_clk_out = 1'b0;
		tx_word_out     = 4'h0;
		tx_parity_out   = 1'b0;
	end

	// One clock pulse per word; the clock stands still between words
	task automatic send(input logic [TX_W-1:0] w, input logic bad);
		@(posedge clk_in);
		tx_word_out   <= w;
		tx_parity_out <= (^w) ^ bad;
		repeat (2) @(posedge clk_in);
		tx_word_clk_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		// Hold time over: invert so stale values never pass as fresh
		tx_word_clk_out <= 1'b0;
		tx_word_out     <= ~w;
		tx_parity_out   <= ~((^w) ^ bad);
		repeat (3) @(posedge clk_in);
	endtask
endmodule // spl_framer_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench of the parallel port lock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import spl_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, dlo = 1'b0, dhi = 1'b0;
	logic        rlo = 1'b0, rhi = 1'b0, loop = 1'b0, rxc = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, rx_run = 1'b0, rx_const = 1'b0;
	logic [3:0]  rxw = 4'h0, rx_exp, addr = 4'h0, txw;
	logic [1:0]  rx_div = 2'h0;
	logic [31:0] wdata = 32'h0, rdat;
	wire  [31:0] rdata;
	wire  [3:0]  ser_w, rx_w, txd;
	wire  [4:0]  dpct;
	wire         txc, txp, ok_n, ovf, ser_v, tsrc, rx_clk, rx_par;
	wire         lock, fb, irq;
	int          seed = 27, n_mismatch = 0, n_tests = 0;
	int          low_n = 0, n_par = 0, n_ovf = 0, k;
	logic [3:0]  q[$];

	// Reference clock, 40 MHz
	always #12.5 clk = ~clk;
	// Recovered clock, 200 ns, toggled every fourth reference edge
	always @(posedge clk) if (rx_run) begin
		rx_div <= rx_div + 2'h1;
		if (rx_div == 2'h3 && rxc) begin
			// Falling edge: new word, settled long before the rise
			rxc <= 1'b0;
			rxw <= rx_const ? 4'h0 : 4'($random(seed));
		end else if (rx_div == 2'h3) begin
			rxc    <= 1'b1;
			rx_exp <= rxw;
		end
	end

	spl_framer_model ptr (.clk_in(clk), .tx_word_clk_out(txc),
		.tx_word_out(txd), .tx_parity_out(txp));
	// Small window keeps the lock phase short
	spl_port_lock #(.FIFO_DEPTH(8), .WIN_EDGES(64), .SER_DIV(8)) uut (
		.ref_clk_in(clk), .rst_in(rst), .tx_word_clk_in(txc),
		.tx_word_in(txd), .tx_parity_in(txp),
		.tx_parity_ok_n_pulse_out(ok_n), .tx_fifo_overflow_flag_out(ovf),
		.ser_word_out(ser_w), .ser_word_valid_out(ser_v),
		.ser_timing_src_out(tsrc), .rx_recovered_clk_in(rxc),
		.rx_deser_word_in(rxw), .rx_clk_out(rx_clk), .rx_word_out(rx_w),
		.rx_parity_out(rx_par), .lock_indicator_out(lock),
		.cdr_ref_fallback_out(fb), .deemph_sel_lo_in(dlo),
		.deemph_sel_hi_in(dhi), .deemph_pct_out(dpct),
		.rate_sel_lo_in(rlo), .rate_sel_hi_in(rhi),
		.loop_timing_sel_in(loop), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .irq_out(irq));

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic [4:0] exp_pct(input int i);
		case (i)
			1: return 5'h0A;
			2: return 5'h14;
			3: return 5'h1E;
			default: return 5'h00;
		endcase
	endfunction
	task automatic summarize;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Transmit side monitor: parity pulse width, overflow, word order
	always @(posedge clk) if (!rst) begin
		if (ok_n === 1'b0) low_n++;
		else if (low_n != 0) begin
			chk("par_low_cycles", low_n, 2);
			n_par++;
			low_n = 0;
		end
		if (ovf === 1'b1) begin
			n_ovf++;
			q.delete(); // A flushed FIFO forgets its words
		end
		if (ser_v === 1'b1 && q.size() != 0)
			chk("ser_word", ser_w, q.pop_front());
	end
	// Receive word and parity follow the forwarded clock edge
	always @(posedge rx_clk) begin
		#1 chk("rx_word", rx_w, rx_exp);
		chk("rx_parity", rx_par, ^rx_exp);
	end
	initial begin
		#2000000 n_mismatch++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk("ok_n_rst", ok_n, 1);
		chk("lock_rst", lock, 0);
		chk("deemph_rst", dpct, 0);
		rx_run <= 1'b1;
		wreg(REG_INT_MASK, 32'hF);
		rreg(REG_INT_MASK, rdat);
		chk("int_mask", rdat, 32'hF);
		rreg(4'h2, rdat);
		chk("unmapped", rdat, 0);
		rreg(REG_CTRL, rdat);
		chk("ctrl_rst", rdat, 1);
		// Every code of the select pins
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{dhi, dlo} <= 2'(i); {rhi, rlo} <= 2'(i); loop <= i[0];
			repeat (6) @(posedge clk);
			#1 chk("deemph", dpct, exp_pct(i));
			chk("timing_src", tsrc, i[0]);
			rreg(REG_STATUS, rdat);
			chk("sts_rate", rdat[9:8], i);
			chk("sts_loop", rdat[4], i[0]);
		end
		@(posedge clk);
		{dhi, dlo, rhi, rlo, loop} <= 5'h00;
		repeat (6) @(posedge clk);
		chk("lock_early", lock, 0);
		// Words pass in order at matched rate
		for (int i = 0; i < 12; i++) begin
			txw = 4'($random(seed));
			q.push_back(txw);
			ptr.send(txw, 1'b0);
		end
		repeat (40) @(posedge clk);
		chk("fifo_drained", q.size(), 0);
		// One bad parity word, then check disabled
		ptr.send(4'h5, 1'b1);
		repeat (20) @(posedge clk);
		chk("par_pulses", n_par, 1);
		rreg(REG_INT_STAT, rdat);
		chk("int_par", rdat[INT_PAR], 1);
		chk("irq_set", irq, 1);
		wreg(REG_INT_STAT, 32'hF);
		rreg(REG_INT_STAT, rdat);
		chk("int_clr", rdat[INT_PAR], 0);
		chk("irq_follow", irq, |rdat[3:0]);
		wreg(REG_CTRL, 32'h0);
		ptr.send(4'h3, 1'b1);
		repeat (20) @(posedge clk);
		chk("par_disabled", n_par, 1);
		wreg(REG_CTRL, 32'h1);
		// Slowest read rate: FIFO overflows once, then empties
		@(posedge clk);
		{rhi, rlo} <= 2'h3;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 12; i++) begin
			txw = 4'($random(seed));
			q.push_back(txw);
			ptr.send(txw, 1'b0);
		end
		chk("ovf_pulses", n_ovf, 1);
		rreg(REG_INT_STAT, rdat);
		chk("int_ovf", rdat[INT_OVF], 1);
		@(posedge clk);
		{rhi, rlo} <= 2'h0;
		repeat (60) @(posedge clk);
		chk("fifo_after_ovf", q.size(), 0);
		// Flush empties a FIFO holding two words at the slowest read rate
		@(posedge clk);
		{rhi, rlo} <= 2'h3;
		ptr.send(4'h9, 1'b0);
		ptr.send(4'h6, 1'b0);
		wreg(REG_CTRL, 32'h3);
		rreg(REG_STATUS, rdat);
		chk("flush_lvl", rdat[19:16], 0);
		@(posedge clk);
		{rhi, rlo} <= 2'h0;
		// Clean recovered clock: lock after capture
		for (k = 0; k < 15000 && lock !== 1'b1; k++) @(posedge clk);
		chk("lock_up", lock, 1);
		// Start the loss case with no stale events
		wreg(REG_INT_STAT, 32'hF);
		// Long run of zeros loses data and falls back
		rx_const <= 1'b1;
		for (k = 0; k < 400 && fb !== 1'b1; k++) @(posedge clk);
		chk("fallback", fb, 1);
		#1 chk("lock_lost", lock, 0);
		rreg(REG_INT_STAT, rdat);
		chk("int_fallback", rdat[INT_FALLBACK], 1);
		chk("int_lock_fell", rdat[INT_WARN], 1);
		chk("irq_fb", irq, 1);
		summarize();
	end
endmodule // testbench
`default_nettype wire

// *** include/spl_pkg.sv ***
// Constants, types and helper functions of the parallel port lock block
// Overview of operation
// RL1 - De-emphasis pins pick off, 10, 20, 30 percent
// RL2 - Transmit word captured on transmit clock rise
// RL3 - FIFO absorbs phase; overflow flags, FIFO resets
// RL4 - Loop timing paces serializer from recovered clock
// RL5 - Receive word updates on recovered clock rise
// RL6 - Even transmit parity; error drops ok two cycles
// RL7 - Receive parity bit travels with each word
// RL8 - Receive parity even, same edge as data
// RL9 - Outside party supplies the reference clock
// RL10 - Lost receive data falls back to reference
// RL11 - Lock drops beyond 100 ppm deviation
// RL12 - Beyond 170 ppm counts as loss of lock
// RL13 - Lock unreliable beyond 500 ppm deviation
// RL14 - Lock low after power-up until captured
// RL15 - Runs of 72 identical bits are tolerated
// RL16 - Capture takes about 3500 bit times
// RL17 - Rate pins choose the parallel clock rate
`default_nettype none
package spl_pkg;
	// Clock and link timing
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned WORD_PERIOD_NS = 200;
	localparam int unsigned WORD_CYC       = WORD_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TX_W           = 4;
	localparam logic [1:0]  PAR_PULSE_CYC  = 2'h2;
	// Lock monitor figures
	localparam int unsigned CID_MAX        = 72;
	localparam int unsigned RUN_W          = $clog2(CID_MAX + 2);
	localparam int unsigned CAPTURE_BITS   = 3500;
	localparam int unsigned CAPTURE_EDGES  = (CAPTURE_BITS + TX_W - 1) / TX_W;
	localparam int unsigned CAP_W          = $clog2(CAPTURE_EDGES + 1);
	localparam int unsigned WARN_PPM       = 100;
	localparam int unsigned LOSS_PPM       = 170;
	localparam int unsigned PPM_SCALE      = 1000000;
	// De-emphasis levels in percent
	localparam logic [4:0]  DEEMPH_OFF     = 5'h00;
	localparam logic [4:0]  DEEMPH_10      = 5'h0A;
	localparam logic [4:0]  DEEMPH_20      = 5'h14;
	localparam logic [4:0]  DEEMPH_30      = 5'h1E;
	// Parallel clock divide, as a shift of the fastest rate
	localparam logic [2:0]  RATE_SH_FULL   = 3'h0;
	localparam logic [2:0]  RATE_SH_HALF   = 3'h1;
	localparam logic [2:0]  RATE_SH_QUART  = 3'h2;
	localparam logic [2:0]  RATE_SH_SIXT   = 3'h4;
	// Register map
	localparam int unsigned ADDR_W         = 4;
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [3:0]  REG_INT_STAT   = 4'h8;
	localparam logic [3:0]  REG_INT_MASK   = 4'hC;
	localparam int unsigned CTRL_PAR_EN    = 0;
	localparam int unsigned CTRL_FLUSH     = 1;
	localparam logic        CTRL_PAR_RST   = 1'h1;
	localparam int unsigned INT_W          = 4;
	localparam int unsigned INT_OVF        = 0;
	localparam int unsigned INT_PAR        = 1;
	localparam int unsigned INT_WARN       = 2;
	localparam int unsigned INT_FALLBACK   = 3;
	localparam int unsigned STS_LOCK       = 0;
	localparam int unsigned STS_FALLBACK   = 1;
	localparam int unsigned STS_LOST       = 2;
	localparam int unsigned STS_WARN       = 3;
	localparam int unsigned STS_LOOP       = 4;
	localparam int unsigned STS_RATE_LSB   = 8;
	localparam int unsigned STS_LVL_LSB    = 16;

	typedef enum logic [1:0] {
		ST_ACQ      = 2'b00,
		ST_LOCK     = 2'b01,
		ST_FALLBACK = 2'b10
	} spl_lock_st_t;

	// Even parity bit over one word
	function automatic logic even_par(input logic [TX_W-1:0] w);
		return ^w;
	endfunction

	// De-emphasis level from the two select pins
	function automatic logic [4:0] deemph_pct(input logic hi, input logic lo);
		case ({hi, lo})
			2'b01:   return DEEMPH_10;
			2'b10:   return DEEMPH_20;
			2'b11:   return DEEMPH_30;
			default: return DEEMPH_OFF;
		endcase
	endfunction

	// Parallel clock divide shift from the two rate pins
	function automatic logic [2:0] rate_shift(input logic hi, input logic lo);
		case ({hi, lo})
			2'b01:   return RATE_SH_HALF;
			2'b10:   return RATE_SH_QUART;
			2'b11:   return RATE_SH_SIXT;
			default: return RATE_SH_FULL;
		endcase
	endfunction

	// True when dev / ref exceeds the given ppm figure
	function automatic logic ppm_over(input logic [31:0] dev,
			input logic [31:0] exp_cyc, input int unsigned ppm);
		return (64'(dev) * 64'(PPM_SCALE)) > (64'(exp_cyc) * 64'(ppm));
	endfunction
endpackage
`default_nettype wire

// *** rtl/spl_freq_mon.sv ***
// Frequency monitor: recovered clock edges against reference cycles
`timescale 1ns/1ps
`default_nettype none
module spl_freq_mon #(
	parameter int unsigned WIN_EDGES = 16384,
	parameter int unsigned BASE_CYC  = spl_pkg::WORD_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       edge_in,
	input  wire logic [2:0] shift_in,
	output logic            done_out,
	output logic            warn_out,
	output logic            loss_out
);
	import spl_pkg::*;

	// Worst window span at the slowest rate, stall margin not included
	localparam longint unsigned MAX_SPAN = 64'(BASE_CYC) * WIN_EDGES * 16;

	if (WIN_EDGES < 2 || MAX_SPAN >= 64'h4000_0000) begin : g_bad_win
		$error("spl_freq_mon: window out of range");
	end

	logic [31:0] edge_cnt_q, edge_cnt_d, cyc_cnt_q, cyc_cnt_d;
	logic [31:0] exp_cyc, dev, meas;
	logic        done_d, warn_d, loss_d, stall, last;

	// Window ends on the last edge, or on a stall when edges stop
	always_comb begin
		exp_cyc    = 32'(BASE_CYC * WIN_EDGES) << shift_in;
		meas       = cyc_cnt_q + 32'h1;
		dev        = (meas > exp_cyc) ? meas - exp_cyc : exp_cyc - meas;
		stall      = cyc_cnt_q > (exp_cyc << 1);
		last       = edge_in && (edge_cnt_q == 32'(WIN_EDGES - 1));
		done_d     = last || stall;
		warn_d     = warn_out;
		loss_d     = loss_out;
		edge_cnt_d = edge_cnt_q + {31'h0, edge_in};
		cyc_cnt_d  = cyc_cnt_q + 32'h1;
		if (done_d) begin
			edge_cnt_d = 32'h0;
			cyc_cnt_d  = 32'h0;
			warn_d     = stall || ppm_over(dev, exp_cyc, WARN_PPM); // RL11
			loss_d     = stall || ppm_over(dev, exp_cyc, LOSS_PPM); // RL12
		end
	end

	// Counters and verdict registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			edge_cnt_q <= 32'h0;
			cyc_cnt_q  <= 32'h0;
			done_out   <= 1'b0;
			warn_out   <= 1'b1;
			loss_out   <= 1'b0;
		end else begin
			edge_cnt_q <= edge_cnt_d;
			cyc_cnt_q  <= cyc_cnt_d;
			done_out   <= done_d;
			warn_out   <= warn_d;
			loss_out   <= loss_d;
		end
	end
endmodule // spl_freq_mon
`default_nettype wire

// *** rtl/spl_port_lock.sv ***
// Parallel port, transmit FIFO, parity and lock logic of the transceiver
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module spl_port_lock #(
	parameter int unsigned FIFO_DEPTH = 8,
	parameter int unsigned WIN_EDGES  = 16384,
	parameter int unsigned SER_DIV    = spl_pkg::WORD_CYC
) (
	input  wire logic                       ref_clk_in,
	input  wire logic                       rst_in,
	input  wire logic                       tx_word_clk_in,
	input  wire logic [spl_pkg::TX_W-1:0]   tx_word_in,
	input  wire logic                       tx_parity_in,
	output logic                            tx_parity_ok_n_pulse_out,
	output logic                            tx_fifo_overflow_flag_out,
	output logic [spl_pkg::TX_W-1:0]        ser_word_out,
	output logic                            ser_word_valid_out,
	output logic                            ser_timing_src_out,
	input  wire logic                       rx_recovered_clk_in,
	input  wire logic [spl_pkg::TX_W-1:0]   rx_deser_word_in,
	output logic                            rx_clk_out,
	output logic [spl_pkg::TX_W-1:0]        rx_word_out,
	output logic                            rx_parity_out,
	output logic                            lock_indicator_out,
	output logic                            cdr_ref_fallback_out,
	input  wire logic                       deemph_sel_lo_in,
	input  wire logic                       deemph_sel_hi_in,
	output logic [4:0]                      deemph_pct_out,
	input  wire logic                       rate_sel_lo_in,
	input  wire logic                       rate_sel_hi_in,
	input  wire logic                       loop_timing_sel_in,
	input  wire logic [spl_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]                reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	output logic [31:0]                     reg_rdata_out,
	output logic                            irq_out
);
	import spl_pkg::*;

	localparam int unsigned AW     = $clog2(FIFO_DEPTH);
	localparam int unsigned LW     = AW + 1;
	localparam int unsigned DIV_W  = 12;
	localparam int unsigned SYNC_W = 2 * TX_W + 8;

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64 ||
			(FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("spl_port_lock: FIFO_DEPTH must be a power of two, 2 to 64");
	end
	if (SER_DIV < 1 || SER_DIV * 16 > (1 << DIV_W)) begin : g_bad_div
		$error("spl_port_lock: SER_DIV out of range");
	end

	// Pin synchronisers; stage a feeds only stage b
	logic [SYNC_W-1:0] sync_a_q, sync_b_q;
	logic              s_tx_word_clk, s_txpar, s_rx_recovered_clk;
	logic              s_dhi, s_dlo, s_rhi, s_rlo, s_loop;
	logic [TX_W-1:0]   s_txw, s_rxw;
	logic              tx_word_clk_c_q, rx_recovered_clk_c_q, tx_edge, rx_edge;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_a_q  <= '0;
			sync_b_q  <= '0;
			tx_word_clk_c_q <= 1'b0;
			rx_recovered_clk_c_q <= 1'b0;
		end else begin
			sync_a_q  <= {tx_word_clk_in, tx_word_in, tx_parity_in,
				rx_recovered_clk_in, rx_deser_word_in, deemph_sel_hi_in,
				deemph_sel_lo_in, rate_sel_hi_in, rate_sel_lo_in,
				loop_timing_sel_in};
			sync_b_q  <= sync_a_q;
			tx_word_clk_c_q <= s_tx_word_clk;
			rx_recovered_clk_c_q <= s_rx_recovered_clk;
		end
	end

	// Unpack and find link clock rises
	assign {s_tx_word_clk, s_txw, s_txpar, s_rx_recovered_clk, s_rxw, s_dhi, s_dlo,
		s_rhi, s_rlo, s_loop} = sync_b_q;
	assign tx_edge = s_tx_word_clk && !tx_word_clk_c_q;
	assign rx_edge = s_rx_recovered_clk && !rx_recovered_clk_c_q;

	// Register bus decode
	logic par_en_q, par_en_d, flush;
	assign flush = reg_wr_in && (reg_addr_in == REG_CTRL) &&
		reg_wdata_in[CTRL_FLUSH];

	// Serializer pacing: reference divider, or recovered clock in loop timing
	logic [DIV_W-1:0] div_q, div_d, div_lim;
	logic [2:0]       rsh;
	logic             rd_tick;

	always_comb begin
		rsh     = rate_shift(s_rhi, s_rlo); // RL17
		div_lim = DIV_W'((SER_DIV << rsh) - 1); // RL9
		div_d   = (div_q >= div_lim) ? '0 : div_q + 1'b1;
		rd_tick = s_loop ? rx_edge : (div_q >= div_lim); // RL4
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// Transmit FIFO between link clock and serializer pacing
	logic [TX_W-1:0] mem [FIFO_DEPTH];
	logic [AW-1:0]   wp_q, wp_d, rp_q, rp_d;
	logic [LW-1:0]   lvl_q, lvl_d;
	logic [TX_W-1:0] ser_d;
	logic            full, wr_en, rd_en, ovf;

	always_comb begin
		full  = lvl_q == LW'(FIFO_DEPTH);
		wr_en = tx_edge && !full && !flush; // RL2
		rd_en = rd_tick && (lvl_q != '0) && !flush;
		ovf   = tx_edge && full;
		wp_d  = wp_q + AW'(wr_en);
		rp_d  = rp_q + AW'(rd_en);
		lvl_d = lvl_q + LW'(wr_en) - LW'(rd_en);
		ser_d = rd_en ? mem[rp_q] : ser_word_out;
		if (ovf || flush) begin
			// Realign: drop everything and restart both pointers
			wp_d  = '0; // RL3
			rp_d  = '0;
			lvl_d = '0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (wr_en) begin
			mem[wp_q] <= s_txw;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_q                      <= '0;
			rp_q                      <= '0;
			lvl_q                     <= '0;
			ser_word_out              <= '0;
			ser_word_valid_out        <= 1'b0;
			tx_fifo_overflow_flag_out <= 1'b0;
			ser_timing_src_out        <= 1'b0;
		end else begin
			wp_q                      <= wp_d;
			rp_q                      <= rp_d;
			lvl_q                     <= lvl_d;
			ser_word_out              <= ser_d;
			ser_word_valid_out        <= rd_en;
			tx_fifo_overflow_flag_out <= ovf; // RL3
			ser_timing_src_out        <= s_loop; // RL4
		end
	end

	// Transmit parity check, low pulse stretched to two cycles
	logic [1:0] par_cnt_q, par_cnt_d;
	logic       par_err;

	always_comb begin
		par_err   = tx_edge && par_en_q && (even_par(s_txw) != s_txpar); // RL6
		par_cnt_d = par_err ? PAR_PULSE_CYC :
			par_cnt_q - 2'(par_cnt_q != 2'h0);
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			par_cnt_q                <= 2'h0;
			tx_parity_ok_n_pulse_out <= 1'b1;
		end else begin
			par_cnt_q                <= par_cnt_d;
			tx_parity_ok_n_pulse_out <= par_cnt_d == 2'h0; // RL6
		end
	end

	// Receive word, parity and identical-run tracking
	logic [RUN_W-1:0] run_q, run_d;
	logic             lastb_q, lastb_d, lost_q, lost_d;

	always_comb begin
		run_d   = run_q;
		lastb_d = lastb_q;
		lost_d  = lost_q;
		if (rx_edge) begin
			// Bit 0 is first in time
			for (int i = 0; i < TX_W; i++) begin
				if (s_rxw[i] == lastb_d) begin
					run_d = (&run_d) ? run_d : run_d + 1'b1;
				end else begin
					run_d = RUN_W'(1);
				end
				lastb_d = s_rxw[i];
			end
			lost_d = run_d > RUN_W'(CID_MAX); // RL15
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			run_q         <= '0;
			lastb_q       <= 1'b0;
			lost_q        <= 1'b0;
			rx_clk_out    <= 1'b0;
			rx_word_out   <= '0;
			rx_parity_out <= 1'b0;
		end else begin
			run_q         <= run_d;
			lastb_q       <= lastb_d;
			lost_q        <= lost_d;
			rx_clk_out    <= s_rx_recovered_clk;
			if (rx_edge) begin
				rx_word_out   <= s_rxw; // RL5
				rx_parity_out <= even_par(s_rxw); // RL7 RL8
			end
		end
	end

	// Frequency comparison of recovered clock to reference
	logic fm_done, fm_warn, fm_loss;

	spl_freq_mon #(
		.WIN_EDGES (WIN_EDGES),
		.BASE_CYC  (SER_DIV)
	) u_freq_mon (
		.clk_in   (ref_clk_in),
		.rst_in   (rst_in),
		.edge_in  (rx_edge),
		.shift_in (rsh),
		.done_out (fm_done),
		.warn_out (fm_warn),
		.loss_out (fm_loss)
	);

	// Lock state: acquire, locked, or fallback to the reference
	spl_lock_st_t     st_q, st_d;
	logic [CAP_W-1:0] cap_q, cap_d;
	logic             cap_full, lock_d, fb_d, lose;

	always_comb begin
		st_d     = st_q;
		cap_d    = cap_q;
		cap_full = cap_q == CAP_W'(CAPTURE_EDGES);
		lose     = lost_q || (fm_done && fm_loss); // RL10 RL12
		case (st_q)
			ST_ACQ: begin
				if (rx_edge && !cap_full) begin
					cap_d = cap_q + 1'b1; // RL16
				end
				if (lose) begin
					st_d = ST_FALLBACK;
				end else if (fm_done && !fm_warn && cap_full) begin
					st_d = ST_LOCK; // RL14
				end
			end
			ST_LOCK: begin
				if (lose) begin
					st_d = ST_FALLBACK;
				end
			end
			ST_FALLBACK: begin
				cap_d = '0;
				if (fm_done && !fm_loss && !lost_q) begin
					st_d = ST_ACQ;
				end
			end
			default: begin
				st_d = ST_ACQ;
			end
		endcase
		// Warning verdict only takes effect at window end
		lock_d = (st_d == ST_LOCK) && !(fm_done ? fm_warn : !lock_indicator_out
			&& st_q == ST_LOCK); // RL11
		fb_d   = st_d == ST_FALLBACK; // RL10
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q                 <= ST_ACQ;
			cap_q                <= '0;
			lock_indicator_out   <= 1'b0;
			cdr_ref_fallback_out <= 1'b0;
			deemph_pct_out       <= DEEMPH_OFF;
		end else begin
			st_q                 <= st_d;
			cap_q                <= cap_d;
			lock_indicator_out   <= lock_d;
			cdr_ref_fallback_out <= fb_d;
			deemph_pct_out       <= deemph_pct(s_dhi, s_dlo); // RL1
		end
	end

	// Registers: sticky events win over a same-cycle clear
	logic [INT_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
	logic [31:0]      rdata_d;

	always_comb begin
		ev               = '0;
		ev[INT_OVF]      = ovf;
		ev[INT_PAR]      = par_err;
		ev[INT_WARN]     = lock_indicator_out && !lock_d;
		ev[INT_FALLBACK] = fb_d && !cdr_ref_fallback_out;
		par_en_d         = par_en_q;
		imask_d          = imask_q;
		ist_d            = ist_q;
		if (reg_wr_in && reg_addr_in == REG_CTRL) begin
			par_en_d = reg_wdata_in[CTRL_PAR_EN];
		end
		if (reg_wr_in && reg_addr_in == REG_INT_MASK) begin
			imask_d = reg_wdata_in[INT_W-1:0];
		end
		if (reg_wr_in && reg_addr_in == REG_INT_STAT) begin
			ist_d = ist_q & ~reg_wdata_in[INT_W-1:0];
		end
		ist_d   = ist_d | ev;
		rdata_d = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				REG_CTRL: rdata_d[CTRL_PAR_EN] = par_en_q;
				REG_STATUS: begin
					rdata_d[STS_LOCK]     = lock_indicator_out;
					rdata_d[STS_FALLBACK] = cdr_ref_fallback_out;
					rdata_d[STS_LOST]     = lost_q;
					rdata_d[STS_WARN]     = fm_warn;
					rdata_d[STS_LOOP]     = s_loop;
					rdata_d[STS_RATE_LSB +: 2]  = {s_rhi, s_rlo};
					rdata_d[STS_LVL_LSB +: LW]  = lvl_q;
				end
				REG_INT_STAT: rdata_d[INT_W-1:0] = ist_q;
				REG_INT_MASK: rdata_d[INT_W-1:0] = imask_q;
				default:      rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			par_en_q      <= CTRL_PAR_RST;
			ist_q         <= '0;
			imask_q       <= '0;
			reg_rdata_out <= '0;
			irq_out       <= 1'b0;
		end else begin
			par_en_q      <= par_en_d;
			ist_q         <= ist_d;
			imask_q       <= imask_d;
			reg_rdata_out <= rdata_d;
			irq_out       <= |(ist_d & imask_d);
		end
	end

	// Checks on the block's own outputs and FIFO level
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	property p_deemph;
		{s_dhi, s_dlo} == 2'b11 |=> deemph_pct_out == DEEMPH_30;
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis wrong"); // RL1

	property p_capture;
		wr_en && !rd_en |=> lvl_q == $past(lvl_q) + 1'b1;
	endproperty
	a_capture: assert property (p_capture) else $error("word not stored"); // RL2

	property p_overflow;
		tx_edge && full && !flush |=> tx_fifo_overflow_flag_out && lvl_q == '0;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow missed"); // RL3

	property p_loop;
		ser_word_valid_out && $past(s_loop) |-> $past(rx_edge);
	endproperty
	a_loop: assert property (p_loop) else $error("loop pacing wrong"); // RL4

	property p_rx_word;
		rx_edge |=> rx_word_out == $past(s_rxw) && rx_clk_out;
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("rx word stale"); // RL5

	property p_par_pulse;
		par_err ##1 !par_err [*2] |-> !tx_parity_ok_n_pulse_out
			##1 tx_parity_ok_n_pulse_out;
	endproperty
	a_par_pulse: assert property (p_par_pulse) else $error("parity pulse"); // RL6

	property p_rx_par;
		rx_edge |=> rx_parity_out == ^rx_word_out;
	endproperty
	a_rx_par: assert property (p_rx_par) else $error("rx parity odd"); // RL8

	property p_fallback;
		lost_q |=> cdr_ref_fallback_out && !lock_indicator_out;
	endproperty
	a_fallback: assert property (p_fallback) else $error("no fallback"); // RL10

	property p_warn;
		fm_done && fm_warn |=> !lock_indicator_out;
	endproperty
	a_warn: assert property (p_warn) else $error("lock kept"); // RL11

	property p_loss;
		fm_done && fm_loss |=> cdr_ref_fallback_out;
	endproperty
	a_loss: assert property (p_loss) else $error("loss not taken"); // RL12

	property p_rise;
		$rose(lock_indicator_out) |-> $past(cap_full) || $past(st_q) == ST_LOCK;
	endproperty
	a_rise: assert property (p_rise) else $error("early lock"); // RL16
endmodule // spl_port_lock
`default_nettype wire
